// ### include/olr_pkg.sv
// shared constants for the output and loop enable control block
package olr_pkg;

    // apb geometry
    localparam int unsigned ADDR_W    = 12;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned CTRL_W    = 12;
    localparam int unsigned NUM_PINS  = 3;

    // register offset (byte address, one aligned word)
    localparam logic [ADDR_W-1:0] OUTPUT_AND_LOOP_ENABLE_CONTROL_OFS = 12'h000;

    // field positions inside output_and_loop_enable_control
    localparam int unsigned FIRST_LOOP_OVERRIDE_BIT             = 0;
    localparam int unsigned FIRST_SYNTH_LOOP_BIT                = 1;
    localparam int unsigned SECOND_LOOP_QUALIFIER_BIT           = 2;
    localparam int unsigned SECOND_SYNTH_LOOP_BIT               = 3;
    localparam int unsigned FIRST_LOOP_REF_CHOICE_QUALIFIER_BIT = 4;
    localparam int unsigned FIRST_LOOP_REF_CHOICE_BIT           = 5;
    localparam int unsigned SECOND_LOOP_REF_CHOICE_QUALIFIER_BIT = 6;
    localparam int unsigned SECOND_LOOP_REF_CHOICE_BIT          = 7;
    localparam int unsigned FIRST_OUTPUT_OVERRIDE_BIT           = 8;
    localparam int unsigned FIRST_OUTPUT_DRIVER_ON_BIT          = 9;
    localparam int unsigned SECOND_OUTPUT_OVERRIDE_BIT          = 10;
    localparam int unsigned SECOND_OUTPUT_DRIVER_ON_BIT         = 11;

    // synchronised pin vector positions
    localparam int unsigned PIN_FIRST_OE  = 0;
    localparam int unsigned PIN_SECOND_OE = 1;
    localparam int unsigned PIN_LOOP1_UP  = 2;

    // reset values
    localparam logic [CTRL_W-1:0]   CTRL_RESET     = 12'h000;
    localparam logic [NUM_PINS-1:0] PIN_SYNC_RESET = 3'h0;
    localparam logic [DATA_W-1:0]   RDATA_RESET    = 32'h0000_0000;

endpackage : olr_pkg

// ### include/olr_ctrl_if.sv
`timescale 1ns/100ps
`default_nettype none
// carries control bits, synchronised pins and decoded results between the modules
interface olr_ctrl_if;
    import olr_pkg::*;

    logic [CTRL_W-1:0]   ctrl;
    logic [NUM_PINS-1:0] pins_sync;
    logic                first_output_driver_on;
    logic                second_output_driver_on;
    logic                first_synth_loop_on;
    logic                second_synth_loop_on;
    logic                first_loop_ref2;
    logic                second_loop_ref2;
    logic                first_output_sel;
    logic                second_output_sel;
    logic                first_loop_sel;

    modport sync (output pins_sync);
    modport dec  (input ctrl, input pins_sync,
                  output first_output_driver_on, output second_output_driver_on,
                  output first_synth_loop_on, output second_synth_loop_on,
                  output first_loop_ref2, output second_loop_ref2,
                  output first_output_sel, output second_output_sel, output first_loop_sel);
    modport top  (output ctrl, input pins_sync,
                  input first_output_driver_on, input second_output_driver_on,
                  input first_synth_loop_on, input second_synth_loop_on,
                  input first_loop_ref2, input second_loop_ref2,
                  input first_output_sel, input second_output_sel, input first_loop_sel);
endinterface : olr_ctrl_if
`default_nettype wire

// ### hdl/olr_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for the enable and power-down pins
module olr_pin_sync (
    // clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // raw pin levels, active high meaning on
    input  wire logic [olr_pkg::NUM_PINS-1:0] pins_raw,
    // synchronised levels
    olr_ctrl_if.sync                          cif
);
    import olr_pkg::*;

    typedef struct packed {
        logic [NUM_PINS-1:0] meta;
        logic [NUM_PINS-1:0] sync;
    } olr_sync_state_t;

    olr_sync_state_t s_r;
    olr_sync_state_t s_nxt;

    // first stage feeds only the second stage
    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = pins_raw;
        s_nxt.sync = s_r.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{meta: PIN_SYNC_RESET, sync: PIN_SYNC_RESET};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cif.pins_sync = s_r.sync;

endmodule : olr_pin_sync
`default_nettype wire

// ### hdl/olr_ctrl_decode.sv
`timescale 1ns/100ps
`default_nettype none
// pure decode of control bits and pin levels into driver, loop and reference choices
module olr_ctrl_decode (
    // control in, decoded out
    olr_ctrl_if.dec cif
);
    import olr_pkg::*;

    // source selection: override bit picks register bit, else the pin
    always_comb begin
        cif.first_output_sel  = cif.ctrl[FIRST_OUTPUT_OVERRIDE_BIT]
                              ? cif.ctrl[FIRST_OUTPUT_DRIVER_ON_BIT]
                              : cif.pins_sync[PIN_FIRST_OE];
        cif.second_output_sel = cif.ctrl[SECOND_OUTPUT_OVERRIDE_BIT]
                              ? cif.ctrl[SECOND_OUTPUT_DRIVER_ON_BIT]
                              : cif.pins_sync[PIN_SECOND_OE];
        cif.first_loop_sel    = cif.ctrl[FIRST_LOOP_OVERRIDE_BIT]
                              ? cif.ctrl[FIRST_SYNTH_LOOP_BIT]
                              : cif.pins_sync[PIN_LOOP1_UP];
    end

    // loops and reference muxes
    always_comb begin
        cif.first_synth_loop_on  = cif.first_loop_sel;
        cif.second_synth_loop_on = cif.ctrl[SECOND_LOOP_QUALIFIER_BIT]
                                 & cif.ctrl[SECOND_SYNTH_LOOP_BIT];
        cif.first_loop_ref2      = cif.ctrl[FIRST_LOOP_REF_CHOICE_QUALIFIER_BIT]
                                 & cif.ctrl[FIRST_LOOP_REF_CHOICE_BIT];
        cif.second_loop_ref2     = cif.ctrl[SECOND_LOOP_REF_CHOICE_QUALIFIER_BIT]
                                 & cif.ctrl[SECOND_LOOP_REF_CHOICE_BIT];
    end

    // drivers are clocked by the second loop, so they only run with it up
    always_comb begin
        cif.first_output_driver_on  = cif.first_output_sel & cif.second_synth_loop_on;
        cif.second_output_driver_on = cif.second_output_sel & cif.second_synth_loop_on;
    end

endmodule : olr_ctrl_decode
`default_nettype wire

// ### hdl/olr_top.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - first-output override set: enable bit turns first driver on or off (code: driver on only while second loop is powered).
// - override clear: first enable bit is read-only, mirrors first output-enable pin.
// - first-output override resets to 0, pin controls first driver (code: driver on only while second loop is powered).
// - second-output override picks enable bit (1) or pin (0, reset).
// - pin in control: second enable bit reads back second pin level.
// - second-loop qualifier set: choice bit picks reference 2 or 1.
// - second-loop qualifier clear (reset): second loop uses reference 1.
// - first-loop qualifier set: choice bit picks reference 2 or 1.
// - first-loop qualifier clear (reset): first loop uses reference 1.
// - second-loop qualifier set: on/off bit powers second loop; bit resets 0.
// - second-loop qualifier clear (reset): second loop stays powered down.
// - first-loop override set: on/off bit enables or disables first loop.
// - override clear: power-down pin controls first loop, bit mirrors pin.
module olr_top (
    // apb clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [olr_pkg::ADDR_W-1:0] paddr,
    input  wire logic [olr_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                 pstrb,
    output var  logic [olr_pkg::DATA_W-1:0] prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    // external control pins
    input  wire logic                       first_output_enable_pin,
    input  wire logic                       second_output_enable_pin,
    input  wire logic                       first_loop_powerdown_pin_n,
    // controls toward drivers, loops and reference muxes
    output var  logic                       first_output_driver_on,
    output var  logic                       second_output_driver_on,
    output var  logic                       first_synth_loop_on,
    output var  logic                       second_synth_loop_on,
    output var  logic                       first_loop_ref2_sel,
    output var  logic                       second_loop_ref2_sel
);
    import olr_pkg::*;

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [DATA_W-1:0] rdata;
        logic              ready;
        logic              slverr;
        logic              out1_on;
        logic              out2_on;
        logic              loop1_on;
        logic              loop2_on;
        logic              ref1_two;
        logic              ref2_two;
    } olr_top_state_t;

    olr_top_state_t s_r;
    olr_top_state_t s_nxt;

    olr_ctrl_if cif ();

    // pin levels; the power-down pin is active low, so high means loop up
    logic [NUM_PINS-1:0] pins_raw;

    assign pins_raw[PIN_FIRST_OE]  = first_output_enable_pin;
    assign pins_raw[PIN_SECOND_OE] = second_output_enable_pin;
    assign pins_raw[PIN_LOOP1_UP]  = first_loop_powerdown_pin_n;

    // metastability guard before any use of the pins
    olr_pin_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .pins_raw (pins_raw),
        .cif      (cif.sync)
    );

    olr_ctrl_decode u_dec (
        .cif (cif.dec)
    );

    assign cif.ctrl = s_r.ctrl;

    // bus decode helpers
    logic setup_ph;
    logic access_ph;
    logic hit;
    logic lane0;
    logic lane1;

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable & s_r.ready;
    assign hit       = (paddr == OUTPUT_AND_LOOP_ENABLE_CONTROL_OFS);
    assign lane0     = pstrb[0];
    assign lane1     = pstrb[1];

    // readback view: read-only bits show the synchronised pin while pins rule
    logic [DATA_W-1:0] view;

    always_comb begin
        view = '0;
        view[CTRL_W-1:0] = s_r.ctrl;
        view[FIRST_OUTPUT_DRIVER_ON_BIT]  = cif.first_output_sel;
        view[SECOND_OUTPUT_DRIVER_ON_BIT] = cif.second_output_sel;
        view[FIRST_SYNTH_LOOP_BIT]        = cif.first_loop_sel;
    end

    // write merge: new override value decides whether the paired bit is writable
    logic [CTRL_W-1:0] wr_ctrl;

    always_comb begin
        wr_ctrl = s_r.ctrl;
        if (lane0) begin
            wr_ctrl[7:0] = pwdata[7:0];
        end
        if (lane1) begin
            wr_ctrl[CTRL_W-1:8] = pwdata[CTRL_W-1:8];
        end
        // a read-only bit keeps its stored value; the pin is shown instead
        if (!wr_ctrl[FIRST_OUTPUT_OVERRIDE_BIT]) begin
            wr_ctrl[FIRST_OUTPUT_DRIVER_ON_BIT] = s_r.ctrl[FIRST_OUTPUT_DRIVER_ON_BIT];
        end
        if (!wr_ctrl[SECOND_OUTPUT_OVERRIDE_BIT]) begin
            wr_ctrl[SECOND_OUTPUT_DRIVER_ON_BIT] = s_r.ctrl[SECOND_OUTPUT_DRIVER_ON_BIT];
        end
        if (!wr_ctrl[FIRST_LOOP_OVERRIDE_BIT]) begin
            wr_ctrl[FIRST_SYNTH_LOOP_BIT] = s_r.ctrl[FIRST_SYNTH_LOOP_BIT];
        end
    end

    // next state: answer in the first cycle of the access phase, outputs registered
    always_comb begin
        s_nxt        = s_r;
        s_nxt.ready  = 1'b0;
        s_nxt.slverr = 1'b0;
        if (setup_ph) begin
            // answer prepared in setup so pready, prdata leave flops
            s_nxt.ready  = 1'b1;
            s_nxt.slverr = ~hit;
            s_nxt.rdata  = (!pwrite && hit) ? view : RDATA_RESET;
        end
        if (access_ph && pwrite && hit) begin
            s_nxt.ctrl = wr_ctrl;
        end
        if (access_ph) begin
            s_nxt.rdata = RDATA_RESET;
        end
        s_nxt.out1_on  = cif.first_output_driver_on;
        s_nxt.out2_on  = cif.second_output_driver_on;
        s_nxt.loop1_on = cif.first_synth_loop_on;
        s_nxt.loop2_on = cif.second_synth_loop_on;
        s_nxt.ref1_two = cif.first_loop_ref2;
        s_nxt.ref2_two = cif.second_loop_ref2;
    end

    // all overrides and qualifiers clear at reset, so the pins rule
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{ctrl: CTRL_RESET, rdata: RDATA_RESET, default: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign prdata                  = s_r.rdata;
    assign pready                  = s_r.ready;
    assign pslverr                 = s_r.slverr;
    assign first_output_driver_on  = s_r.out1_on;
    assign second_output_driver_on = s_r.out2_on;
    assign first_synth_loop_on     = s_r.loop1_on;
    assign second_synth_loop_on    = s_r.loop2_on;
    assign first_loop_ref2_sel     = s_r.ref1_two;
    assign second_loop_ref2_sel    = s_r.ref2_two;

endmodule : olr_top
`default_nettype wire

// ### verif/olr_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
// bus timing and decode relations seen from the block's ports only
module olr_top_checker (
    // clock and reset
    input wire logic                       pclk,
    input wire logic                       presetn,
    // apb slave
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [olr_pkg::ADDR_W-1:0] paddr,
    input wire logic [olr_pkg::DATA_W-1:0] prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    // decoded controls
    input wire logic                       first_output_driver_on,
    input wire logic                       second_output_driver_on,
    input wire logic                       first_synth_loop_on,
    input wire logic                       second_synth_loop_on,
    input wire logic                       first_loop_ref2_sel,
    input wire logic                       second_loop_ref2_sel
);
    import olr_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // register driven only: ctrl loads at the write edge, the output flop one edge later,
    // so the change is seen two sampling edges after the write edge
    property p_loop2_ref_by_write;
        $changed(second_loop_ref2_sel) |-> $past(psel && penable && pwrite && pready, 2);
    endproperty
    property p_loop1_ref_by_write;
        $changed(first_loop_ref2_sel) |-> $past(psel && penable && pwrite && pready, 2);
    endproperty
    property p_loop2_power_by_write;
        $changed(second_synth_loop_on) |-> $past(psel && penable && pwrite && pready, 2);
    endproperty
    property p_first_drv_needs_loop2;
        first_output_driver_on |-> second_synth_loop_on;
    endproperty
    property p_second_drv_needs_loop2;
        second_output_driver_on |-> second_synth_loop_on;
    endproperty
    // first edge after release: everything still quiet
    property p_reset_quiet;
        $rose(presetn) |-> !pready && !first_output_driver_on && !second_output_driver_on && !first_synth_loop_on
                           && !second_synth_loop_on && !first_loop_ref2_sel && !second_loop_ref2_sel;
    endproperty
    property p_ready_after_setup;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    property p_err_unmapped;
        psel && !penable && paddr != OUTPUT_AND_LOOP_ENABLE_CONTROL_OFS |=> pslverr && pready && prdata == 32'h0;
    endproperty
    property p_rdata_quiet;
        !pready |-> prdata == 32'h0 && !pslverr;
    endproperty

    a_loop2_ref_by_write:     assert property (p_loop2_ref_by_write) else $error("second loop ref moved without write");
    a_loop1_ref_by_write:     assert property (p_loop1_ref_by_write) else $error("first loop ref moved without write");
    a_loop2_power_by_write:   assert property (p_loop2_power_by_write) else $error("second loop power moved without write");
    a_first_drv_needs_loop2:  assert property (p_first_drv_needs_loop2) else $error("first driver on with loop2 off");
    a_second_drv_needs_loop2: assert property (p_second_drv_needs_loop2) else $error("second driver on with loop2 off");
    a_reset_quiet:            assert property (p_reset_quiet) else $error("outputs active after reset");
    a_ready_after_setup:      assert property (p_ready_after_setup) else $error("ready not a single pulse after setup");
    a_err_unmapped:           assert property (p_err_unmapped) else $error("unmapped access without error");
    a_rdata_quiet:            assert property (p_rdata_quiet) else $error("read data or error outside ready");

    // main scenarios
    c_unmapped:  cover property (pslverr);
    c_drv_on:    cover property (first_output_driver_on && second_output_driver_on);
    c_ref2_both: cover property (first_loop_ref2_sel && second_loop_ref2_sel);
endmodule : olr_top_checker

bind olr_top olr_top_checker chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_output_driver_on(first_output_driver_on), .second_output_driver_on(second_output_driver_on),
    .first_synth_loop_on(first_synth_loop_on), .second_synth_loop_on(second_synth_loop_on),
    .first_loop_ref2_sel(first_loop_ref2_sel), .second_loop_ref2_sel(second_loop_ref2_sel)
);
`default_nettype wire

// ### verif/olr_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module olr_top_tb;
    import olr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, oe1, oe2, pdn;
    logic [3:0] pstrb, lanes;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [5:0] outs;
    logic err;
    int num_errors, num_checks;

    olr_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_output_enable_pin(oe1), .second_output_enable_pin(oe2), .first_loop_powerdown_pin_n(pdn),
        .first_output_driver_on(outs[5]), .second_output_driver_on(outs[4]), .first_synth_loop_on(outs[3]),
        .second_synth_loop_on(outs[2]), .first_loop_ref2_sel(outs[1]), .second_loop_ref2_sel(outs[0])
    );

    // clock; reset is driven by the main sequence
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wclk(input int n);
        repeat (n) @(posedge pclk);
    endtask : wclk

    // one apb transfer; an edge first so no signal is driven twice in one step
    // no local limit on the wait: only the watchdog may end a hung transfer
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        pstrb <= wr ? lanes : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // write, let decode flops settle, compare outputs
    task automatic wr_out(input logic [31:0] d, input logic [5:0] exp);
        apb(1'b1, 12'h000, d);
        wclk(3);
        chk({26'h0, outs}, {26'h0, exp});
    endtask : wr_out

    task automatic rd_chk(input logic [31:0] exp);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, exp);
    endtask : rd_chk

    task automatic t_reset;
        rd_chk(32'h0000_0002);
        chk({26'h0, outs}, 32'h0000_0008);
    endtask : t_reset

    // read-only bits: writes dropped, pins reflected
    task automatic t_readonly;
        oe1 <= 1'b1; oe2 <= 1'b0; pdn <= 1'b0;
        wclk(4);
        wr_out(32'h0000_0802, 6'b000000);
        rd_chk(32'h0000_0200);
    endtask : t_readonly

    task automatic t_loop2;
        wr_out(32'h0000_000c, 6'b100100);
        wr_out(32'h0000_0008, 6'b000000);
        rd_chk(32'h0000_0208);
    endtask : t_loop2

    // all qualifier and choice combinations of both loops
    task automatic t_refs;
        for (int i = 0; i < 16; i++) begin
            wr_out(32'(i) << 4 | 32'hc, {4'b1001, 1'(i % 4 == 3), 1'(i / 4 == 3)});
        end
    endtask : t_refs

    task automatic t_override;
        wr_out(32'h0000_050d, 6'b000100);
        wr_out(32'h0000_0f0f, 6'b111100);
        oe1 <= 1'b0; oe2 <= 1'b0;
        wclk(4);
        chk({26'h0, outs}, 32'h0000_003c);
        rd_chk(32'h0000_0f0f);
    endtask : t_override

    task automatic t_unmapped;
        apb(1'b1, 12'h004, 32'h0000_0000);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        rd_chk(32'h0000_0f0f);
        oe2 <= 1'b1;
        wr_out(32'h0000_0000, 6'b000000);
        rd_chk(32'h0000_0800);
        // lane 1 gated off: overrides in bits 11:8 must stay clear
        lanes <= 4'h1;
        wr_out(32'h0000_050c, 6'b010100);
        rd_chk(32'h0000_080c);
        lanes <= 4'hf;
    endtask : t_unmapped

    // mid-run reset clears every stored bit, pins rule again
    task automatic t_midreset;
        presetn <= 1'b0;
        wclk(2);
        presetn <= 1'b1;
        wclk(4);
        rd_chk(32'h0000_0800);
        chk({26'h0, outs}, 32'h0);
    endtask : t_midreset

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        oe1 = 1'b0; oe2 = 1'b0; pdn = 1'b1; num_errors = 0; num_checks = 0;
        pstrb = 4'h0; lanes = 4'hf;
        wclk(5);
        presetn <= 1'b1;
        wclk(4);
        t_reset();
        t_readonly();
        t_loop2();
        t_refs();
        t_override();
        t_unmapped();
        t_midreset();
        test_done();
    end

    // watchdog, far beyond the roughly 190 cycles needed
    initial begin
        wclk(5000);
        num_errors++;
        test_done();
    end
endmodule : olr_top_tb
`default_nettype wire
